//--- core/vcc_pkg.sv
// shared constants and types for the video crosspoint control block
// assumes a single 125 MHz clock domain and an AXI4-Lite master
package vcc_pkg;

    localparam int NUM_IN = 5;
    localparam int NUM_OUT = 3;
    localparam int NUM_PORT = 8;

    // register byte addresses
    localparam logic [7:0] ADDR_ROUTE_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ROUTE = 8'h08;
    localparam logic [7:0] ADDR_FED = 8'h0c;
    localparam logic [7:0] ADDR_LOCK = 8'h10;
    localparam logic [7:0] ADDR_MUTE = 8'h14;
    localparam logic [7:0] ADDR_POLICY = 8'h18;
    localparam logic [7:0] ADDR_INCLUDE = 8'h1c;
    localparam logic [7:0] ADDR_SWITCHABLE = 8'h20;
    localparam logic [7:0] ADDR_PRESENCE = 8'h24;
    localparam logic [7:0] ADDR_PROT = 8'h28;
    // priority words: 0x40 + out*0x20 + in*4, out field in addr[7:5]
    localparam logic [2:0] PRIO_OUT_FIRST = 3'h2;
    localparam logic [2:0] PRIO_OUT_LAST = 3'h4;

    // reset values
    localparam logic [7:0] RST_LOCK = 8'h00;
    localparam logic [7:0] RST_MUTE = 8'h00;
    localparam logic [14:0] RST_INCLUDE = 15'h7fff;
    localparam logic [6:0] RST_PRIO = 7'h32;
    localparam logic [9:0] RST_PROT = 10'h155;

    // limits
    localparam logic [6:0] PRIO_MIN = 7'h01;
    localparam logic [6:0] PRIO_MAX = 7'h64;
    localparam logic [3:0] MAX_V22_INPUTS = 4'h2;
    localparam logic [2:0] IN_EXCL_A = 3'h1;
    localparam logic [2:0] IN_EXCL_B = 3'h5;
    localparam logic [2:0] IN_MAX = 3'h5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        POL_OFF = 2'b00,
        POL_LAST = 2'b01,
        POL_FIRST = 2'b10
    } vcc_policy_t;

    typedef enum logic [1:0] {
        SW_OK = 2'b00,
        SW_BUSY = 2'b01,
        SW_LOCKED = 2'b10
    } vcc_switchable_t;

    typedef enum logic [1:0] {
        PROT_OFF = 2'b00,
        PROT_V14 = 2'b01,
        PROT_V22 = 2'b10
    } vcc_prot_t;

    // route command word
    typedef struct packed {
        logic [22:0] unused;
        logic all;
        logic [1:0] pad1;
        logic [1:0] out;
        logic pad0;
        logic [2:0] inp;
    } vcc_cmd_t;

    typedef struct packed {
        logic [29:0] rsvd;
        logic prot_refused;
        logic route_refused;
    } vcc_status_t;

endpackage : vcc_pkg

//--- core/vcc_crosspoint_ctrl.sv
// control logic of a 5-input, 3-output video crosspoint with autoselect
// assumes an AXI4-Lite master on aclk and asynchronous presence pins
//
// Operation
// - input zero disconnects the output
// - inputs one and five never routed together
// - exclusivity breach refused, routing kept, error
// - route-all sends one input everywhere
// - per-port lock flag, read back
// - per-port mute flag, read back
// - per-output policy; off means no autoswitch
// - last-detect takes latest attached input
// - first-detect takes first active input
// - excluded inputs ignored by autoselect
// - priority 1 to 100, ties allowed
// - priorities stored per output
// - routed input readable per output
// - fed outputs readable per input
// - switchability reports OK when allowed
// - switchability reports Busy on exclusivity
// - switchability reports Locked on locked input
// - per-port video presence flag
// - protection level off, 1.4 or 2.2
// - at most two inputs at 2.2
`timescale 1ns/1ns
module vcc_crosspoint_ctrl
    import vcc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // video ports: bits 4:0 inputs one..five, 7:5 outputs one..three
    input wire logic [7:0] presence_pin,
    output logic [7:0] video_presence_flag,
    // per output, three bits each: source fed to the video mux, 0 = none
    output logic [8:0] out_source,
    // per input, two bits each: advertised_protection_level
    output logic [9:0] advertised_protection_level
);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // lowest value wins, ties go to the lower input number
    function automatic logic [2:0] best_pick(input logic [4:0] mask,
                                             input logic [4:0][6:0] pr);
        logic [2:0] sel;
        logic [6:0] bp;
        sel = 3'h0;
        bp = 7'h7f;
        for (int i = 0; i < NUM_IN; i++) begin
            if (mask[i] && (pr[i] < bp)) begin
                sel = 3'(i + 1);
                bp = pr[i];
            end
        end
        return sel;
    endfunction : best_pick

    function automatic vcc_switchable_t sw_check(input logic [2:0] inp, input logic [1:0] oi,
                                                 input logic [2:0][2:0] rt,
                                                 input logic [7:0] lk);
        vcc_switchable_t res;
        logic [2:0] other;
        res = SW_OK;
        other = (inp == IN_EXCL_A) ? IN_EXCL_B : IN_EXCL_A;
        if (inp > IN_MAX) begin
            res = SW_BUSY;
        end else if ((inp != 3'h0 && lk[3'(inp - 3'h1)]) || lk[NUM_IN + 32'(oi)]) begin
            res = SW_LOCKED;
        end else if (inp == IN_EXCL_A || inp == IN_EXCL_B) begin
            for (int o = 0; o < NUM_OUT; o++) begin
                if (o != 32'(oi) && rt[o] == other) begin
                    res = SW_BUSY;
                end
            end
        end
        return res;
    endfunction : sw_check

    function automatic logic [3:0] count_v22(input logic [9:0] p);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < NUM_IN; i++) begin
            if (p[i*2 +: 2] == PROT_V22) begin
                n = n + 4'h1;
            end
        end
        return n;
    endfunction : count_v22

    // bus state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, wdata_ff;
    logic [7:0] waddr_ff;
    logic [3:0] wstrb_ff;

    // block state
    logic [2:0][2:0] route_ff;
    logic [7:0] lock_ff, mute_ff;
    logic [2:0][1:0] policy_ff;
    logic [2:0][4:0] incl_ff;
    logic [2:0][4:0][6:0] prio_ff;
    logic [9:0] prot_ff;
    logic [2:0][4:0] pend_ff;
    logic [1:0] rr_ff;
    vcc_status_t status_ff;
    logic [7:0] sync1_ff, sync2_ff, sync3_ff, pres_ff, pres_prev_ff;
    logic [8:0] out_source_ff;

    // write decode
    wire wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
    wire [31:0] wr_merged_lock = merge({24'h0, lock_ff}, wdata_ff, wstrb_ff);
    wire [31:0] wr_merged_mute = merge({24'h0, mute_ff}, wdata_ff, wstrb_ff);
    wire [31:0] wr_merged_pol = merge({26'h0, policy_ff}, wdata_ff, wstrb_ff);
    wire [31:0] wr_merged_incl = merge({17'h0, incl_ff}, wdata_ff, wstrb_ff);
    wire [31:0] wr_merged_prot = merge({22'h0, prot_ff}, wdata_ff, wstrb_ff);
    wire hit_route_cmd = waddr_ff == ADDR_ROUTE_CMD;
    wire hit_lock = waddr_ff == ADDR_LOCK;
    wire hit_mute = waddr_ff == ADDR_MUTE;
    wire hit_policy = waddr_ff == ADDR_POLICY;
    wire hit_incl = waddr_ff == ADDR_INCLUDE;
    wire hit_prot = waddr_ff == ADDR_PROT;
    wire hit_plain = waddr_ff <= ADDR_PROT && waddr_ff[1:0] == 2'h0;
    wire hit_prio_w = waddr_ff[7:5] >= PRIO_OUT_FIRST && waddr_ff[7:5] <= PRIO_OUT_LAST
        && waddr_ff[4:2] < 3'(NUM_IN) && waddr_ff[1:0] == 2'h0;
    wire [1:0] prio_wo = 2'(waddr_ff[7:5] - PRIO_OUT_FIRST);
    wire [2:0] prio_wi = waddr_ff[4:2];
    wire [31:0] prio_new = merge({25'h0, prio_ff[prio_wo][prio_wi]}, wdata_ff, wstrb_ff);
    wire prio_ok = prio_new[31:7] == 25'h0 && prio_new[6:0] >= PRIO_MIN
        && prio_new[6:0] <= PRIO_MAX;
    wire policy_ok = wr_merged_pol[1:0] != 2'b11 && wr_merged_pol[3:2] != 2'b11
        && wr_merged_pol[5:4] != 2'b11;
    wire prot_codes_ok = wr_merged_prot[1:0] != 2'b11 && wr_merged_prot[3:2] != 2'b11
        && wr_merged_prot[5:4] != 2'b11 && wr_merged_prot[7:6] != 2'b11
        && wr_merged_prot[9:8] != 2'b11;
    wire prot_ok = prot_codes_ok && count_v22(wr_merged_prot[9:0]) <= MAX_V22_INPUTS;

    // route command checks
    vcc_cmd_t cmd;
    assign cmd = vcc_cmd_t'(wdata_ff);
    wire cmd_in_valid = cmd.inp <= IN_MAX;
    wire cmd_in_locked = cmd.inp != 3'h0 && cmd_in_valid && lock_ff[3'(cmd.inp - 3'h1)];
    wire all_ok = cmd_in_valid && !cmd_in_locked && lock_ff[7:5] == 3'h0;
    wire one_ok = cmd.out < 2'(NUM_OUT) && cmd_in_valid
        && sw_check(cmd.inp, cmd.out, route_ff, lock_ff) == SW_OK;
    wire cmd_ok = cmd.all ? all_ok : one_ok;
    wire route_wr = wr_fire && hit_route_cmd;
    wire wr_err = !(hit_plain || hit_prio_w) || (route_wr && !cmd_ok)
        || (hit_prio_w && !prio_ok) || (hit_policy && !policy_ok) || (hit_prot && !prot_ok);

    // autoselect, one output served per cycle so two outputs never race
    wire [1:0] rr_policy = policy_ff[rr_ff];
    wire [2:0] rr_route = route_ff[rr_ff];
    wire [4:0] rr_incl = incl_ff[rr_ff];
    wire rr_cur_present = rr_route != 3'h0 && pres_ff[3'(rr_route - 3'h1)];
    wire [4:0] rr_mask = (rr_policy == POL_LAST) ? (pend_ff[rr_ff] & rr_incl)
        : (rr_policy == POL_FIRST && !rr_cur_present) ? (pres_ff[4:0] & rr_incl)
        : 5'h0;
    wire [2:0] rr_pick = best_pick(rr_mask, prio_ff[rr_ff]);
    wire as_go = rr_pick != 3'h0 && rr_pick != rr_route && !route_wr
        && sw_check(rr_pick, rr_ff, route_ff, lock_ff) == SW_OK;
    wire [4:0] rise = pres_ff[4:0] & ~pres_prev_ff[4:0];
    wire [1:0] nxt_rr = (rr_ff == 2'(NUM_OUT - 1)) ? 2'h0 : rr_ff + 2'h1;

    // presence filter: a change counts once stages two and three agree
    wire [7:0] nxt_pres = (sync2_ff & sync3_ff) | (pres_ff & (sync2_ff ^ sync3_ff));

    // read-only views
    logic [14:0] fed_map;
    logic [29:0] sw_map;
    logic [8:0] nxt_out_source;
    for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
        wire [2:0] r = route_ff[o];
        wire in_muted = r != 3'h0 && mute_ff[3'(r - 3'h1)];
        assign nxt_out_source[o*3 +: 3] = (mute_ff[NUM_IN + o] || in_muted) ? 3'h0 : r;
        for (genvar i = 0; i < NUM_IN; i++) begin : g_in
            assign fed_map[i*3 + o] = route_ff[o] == 3'(i + 1);
            assign sw_map[(o*5 + i)*2 +: 2] =
                sw_check(3'(i + 1), 2'(o), route_ff, lock_ff);
        end
    end

    // read decode
    wire [7:0] ra = s_axi_araddr;
    wire rd_prio = ra[7:5] >= PRIO_OUT_FIRST && ra[7:5] <= PRIO_OUT_LAST
        && ra[4:2] < 3'(NUM_IN) && ra[1:0] == 2'h0;
    wire [1:0] prio_ro = 2'(ra[7:5] - PRIO_OUT_FIRST);
    wire rd_hit = rd_prio || (ra <= ADDR_PROT && ra[1:0] == 2'h0);
    wire [31:0] rd_val =
        rd_prio ? {25'h0, prio_ff[prio_ro][ra[4:2]]}
        : (ra == ADDR_STATUS) ? 32'(status_ff)
        : (ra == ADDR_ROUTE) ? {23'h0, route_ff}
        : (ra == ADDR_FED) ? {17'h0, fed_map}
        : (ra == ADDR_LOCK) ? {24'h0, lock_ff}
        : (ra == ADDR_MUTE) ? {24'h0, mute_ff}
        : (ra == ADDR_POLICY) ? {26'h0, policy_ff}
        : (ra == ADDR_INCLUDE) ? {17'h0, incl_ff}
        : (ra == ADDR_SWITCHABLE) ? {2'h0, sw_map}
        : (ra == ADDR_PRESENCE) ? {24'h0, pres_ff}
        : (ra == ADDR_PROT) ? {22'h0, prot_ff}
        : 32'h0;

    // write channels: one write in flight, address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {awready_ff, wready_ff, bvalid_ff} <= 3'b110;
            bresp_ff <= RESP_OKAY;
            {waddr_ff, wdata_ff, wstrb_ff} <= '0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                waddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {arready_ff, rvalid_ff} <= 2'b10;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    // routing: bus command wins over autoselect in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_ff <= '0;
        end else if (route_wr && cmd_ok && cmd.all) begin
            route_ff <= {3{cmd.inp}};
        end else if (route_wr && cmd_ok) begin
            route_ff[cmd.out] <= cmd.inp;
        end else if (as_go) begin
            route_ff[rr_ff] <= rr_pick;
        end
    end

    // status: result of the latest route command and protection write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= '0;
        end else begin
            if (route_wr) begin
                status_ff.route_refused <= !cmd_ok;
            end
            if (wr_fire && hit_prot) begin
                status_ff.prot_refused <= !prot_ok;
            end
        end
    end

    // software-written settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_ff <= RST_LOCK;
            mute_ff <= RST_MUTE;
            policy_ff <= '0;
            incl_ff <= RST_INCLUDE;
            prot_ff <= RST_PROT;
        end else if (wr_fire) begin
            if (hit_lock) begin
                lock_ff <= wr_merged_lock[7:0];
            end
            if (hit_mute) begin
                mute_ff <= wr_merged_mute[7:0];
            end
            if (hit_policy && policy_ok) begin
                policy_ff <= wr_merged_pol[5:0];
            end
            if (hit_incl) begin
                incl_ff <= wr_merged_incl[14:0];
            end
            if (hit_prot && prot_ok) begin
                prot_ff <= wr_merged_prot[9:0];
            end
        end
    end

    // priorities, one word per output and input pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_ff <= {15{RST_PRIO}};
        end else if (wr_fire && hit_prio_w && prio_ok) begin
            prio_ff[prio_wo][prio_wi] <= prio_new[6:0];
        end
    end

    // pending attach events; a new event beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_ff <= '0;
            rr_ff <= 2'h0;
        end else begin
            rr_ff <= nxt_rr;
            for (int o = 0; o < NUM_OUT; o++) begin
                pend_ff[o] <= ((rr_ff == 2'(o)) ? 5'h0 : pend_ff[o])
                    | ((policy_ff[o] == POL_LAST) ? (rise & incl_ff[o]) : 5'h0);
            end
        end
    end

    // presence pins cross in through three stages
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {sync1_ff, sync2_ff, sync3_ff, pres_ff, pres_prev_ff} <= '0;
        end else begin
            sync1_ff <= presence_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pres_ff <= nxt_pres;
            pres_prev_ff <= pres_ff;
        end
    end

    // video mux select, zero while muted or disconnected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_source_ff <= 9'h000;
        end else begin
            out_source_ff <= nxt_out_source;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign video_presence_flag = pres_ff;
    assign out_source = out_source_ff;
    assign advertised_protection_level = prot_ff;

endmodule : vcc_crosspoint_ctrl

//--- sim/vcc_crosspoint_ctrl_sva.sv
// checker for the crosspoint control block, sees top ports only
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
module vcc_crosspoint_ctrl_chk import vcc_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // video side
    input wire logic [7:0] presence_pin,
    input wire logic [7:0] video_presence_flag,
    input wire logic [8:0] out_source,
    input wire logic [9:0] advertised_protection_level
);
    logic has1, has5, bad_src, bad_code;
    logic [3:0] n22;

    always_comb begin
        has1 = 1'b0;
        has5 = 1'b0;
        bad_src = 1'b0;
        for (int o = 0; o < NUM_OUT; o++) begin
            has1 |= out_source[3*o+:3] == IN_EXCL_A;
            has5 |= out_source[3*o+:3] == IN_EXCL_B;
            bad_src |= out_source[3*o+:3] > IN_MAX;
        end
    end

    always_comb begin
        n22 = 4'h0;
        bad_code = 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            n22 += {3'h0, advertised_protection_level[2*i+:2] == PROT_V22};
            bad_code |= advertised_protection_level[2*i+:2] == 2'h3;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_EXCL: assert property (!(has1 && has5))
        else $error("inputs one and five driven together");
    AST_V22: assert property (n22 <= MAX_V22_INPUTS)
        else $error("too many inputs at level 2.2");
    AST_CODE: assert property (!bad_code)
        else $error("illegal protection code");
    AST_SRC: assert property (!bad_src)
        else $error("output source out of range");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_BANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_BBLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    AST_RANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_PRES: assert property ((aresetn && $stable(presence_pin)) [*8] |->
        video_presence_flag == presence_pin)
        else $error("presence flag does not follow pin");
endmodule : vcc_crosspoint_ctrl_chk

bind vcc_crosspoint_ctrl vcc_crosspoint_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .presence_pin(presence_pin), .video_presence_flag(video_presence_flag),
    .out_source(out_source), .advertised_protection_level(advertised_protection_level));

//--- sim/vcc_client_model.sv
// axi4-lite client issuing routing and query requests
// assumes tasks are entered just after a rising edge
`timescale 1ns/1ns
module vcc_client_model (
    // clock
    input wire logic aclk,
    // write
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
    end

    // released payload is inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa = 1'b1;
        logic pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && awready) begin
                pa = 1'b0;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (pw && wready) begin
                pw = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
endmodule : vcc_client_model

//--- sim/vcc_crosspoint_ctrl_tb.sv
// self-checking bench for the crosspoint control block
// assumes the client model owns the register bus
`timescale 1ns/1ns
module vcc_crosspoint_ctrl_tb import vcc_pkg::*; ();
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t got %h exp %h", $time, a, e); end end
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr, araddr, presence_pin, video_presence_flag;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [8:0] out_source;
    logic [9:0] advertised_protection_level;
    logic [31:0] d;
    logic [1:0] r;
    int num_errors = 0;
    int checks = 0;

    vcc_crosspoint_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .presence_pin(presence_pin),
        .video_presence_flag(video_presence_flag), .out_source(out_source),
        .advertised_protection_level(advertised_protection_level));

    vcc_client_model cli (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        cli.wr(a, d, r);
        `CHK(r, e)
    endtask : wx

    task automatic rx(input logic [7:0] a, input logic [31:0] e);
        cli.rd(a, d, r);
        `CHK(r, RESP_OKAY)
        `CHK(d, e)
    endtask : rx

    task automatic t_reset();
        rx(ADDR_LOCK, 32'h0);
        rx(ADDR_MUTE, 32'h0);
        rx(ADDR_INCLUDE, 32'h7fff);
        rx(8'h40, 32'h32);
        rx(ADDR_PROT, 32'h155);
        `CHK(advertised_protection_level, 10'h155)
        cli.rd(8'h30, d, r);
        `CHK(r, RESP_SLVERR)
    endtask : t_reset

    task automatic t_route();
        wx(ADDR_ROUTE_CMD, 32'h001, RESP_OKAY);
        rx(ADDR_ROUTE, 32'h1);
        rx(ADDR_FED, 32'h1);
        wx(ADDR_ROUTE_CMD, 32'h015, RESP_SLVERR);
        rx(ADDR_STATUS, 32'h1);
        rx(ADDR_ROUTE, 32'h1);
        cli.rd(ADDR_SWITCHABLE, d, r);
        `CHK(d[21:18], 4'h1)
        wx(ADDR_ROUTE_CMD, 32'h000, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(out_source, 9'h000)
        wx(ADDR_ROUTE_CMD, 32'h103, RESP_OKAY);
        rx(ADDR_ROUTE, 32'hdb);
        rx(ADDR_FED, 32'h1c0);
        repeat (2) @(posedge aclk);
        `CHK(out_source, 9'h0db)
    endtask : t_route

    task automatic t_flags();
        wx(ADDR_MUTE, 32'h20, RESP_OKAY);
        rx(ADDR_MUTE, 32'h20);
        repeat (2) @(posedge aclk);
        `CHK(out_source, 9'h0d8)
        rx(ADDR_ROUTE, 32'hdb);
        wx(ADDR_MUTE, 32'h0, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(out_source, 9'h0db)
        wx(ADDR_LOCK, 32'h02, RESP_OKAY);
        rx(ADDR_LOCK, 32'h02);
        cli.rd(ADDR_SWITCHABLE, d, r);
        `CHK(d[3:2], 2'h2)
        wx(ADDR_ROUTE_CMD, 32'h002, RESP_SLVERR);
        wx(ADDR_LOCK, 32'h0, RESP_OKAY);
    endtask : t_flags

    task automatic t_prio_prot();
        wx(8'h64, 32'h64, RESP_OKAY);
        wx(8'h84, 32'h64, RESP_OKAY);
        rx(8'h44, 32'h32);
        wx(8'h64, 32'h65, RESP_SLVERR);
        wx(8'h64, 32'h0, RESP_SLVERR);
        rx(8'h64, 32'h64);
        wx(ADDR_PROT, 32'h02a, RESP_SLVERR);
        wx(ADDR_PROT, 32'h003, RESP_SLVERR);
        wx(ADDR_PROT, 32'h00a, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(advertised_protection_level, 10'h00a)
    endtask : t_prio_prot

    // filter and round-robin autoselect both settle within a dozen edges
    task automatic t_auto();
        presence_pin <= 8'h15;
        repeat (12) @(posedge aclk);
        `CHK(video_presence_flag, 8'h15)
        rx(ADDR_PRESENCE, 32'h15);
        rx(ADDR_POLICY, 32'h0);
        rx(ADDR_ROUTE, 32'hdb);
        wx(ADDR_INCLUDE, 32'h0bff, RESP_OKAY);
        presence_pin <= 8'h03;
        wx(ADDR_POLICY, 32'h20, RESP_OKAY);
        repeat (12) @(posedge aclk);
        rx(ADDR_ROUTE, 32'h9b);
        wx(ADDR_POLICY, 32'h21, RESP_OKAY);
        repeat (4) @(posedge aclk);
        presence_pin <= 8'h0b;
        repeat (12) @(posedge aclk);
        rx(ADDR_ROUTE, 32'h9c);
    endtask : t_auto

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        aresetn = 1'b0;
        presence_pin = 8'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_route();
        t_flags();
        t_prio_prot();
        t_auto();
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        tally_and_finish();
    end
endmodule : vcc_crosspoint_ctrl_tb
